//--- fir_cell_regs.vh
// Register map, field layout and constants of the three-tap FIR cascade cell.
`ifndef FIR_CELL_REGS_VH
`define FIR_CELL_REGS_VH

// ==========================================================================
// Register byte offsets
`define OFS_CTRL        4'h0
`define OFS_COEF        4'h4
`define OFS_STATUS      4'h8
`define OFS_RESULT      4'hc

// ==========================================================================
// Control register fields
`define CTRL_FT_LSB     0
`define CTRL_FT_MSB     2
`define CTRL_OE_BIT     3
`define CTRL_FT_RESET   3'h7
`define CTRL_OE_RESET   1'h0

// ==========================================================================
// Coefficient write register fields
`define COEF_VAL_LSB    0
`define COEF_VAL_MSB    9
`define COEF_SEL_LSB    10
`define COEF_SEL_MSB    11
`define SEL_NONE        2'h0

// ==========================================================================
// Status register fields
`define STAT_OVF_BIT    0
`define STAT_LVL_LSB    1
`define STAT_LVL_MSB    4

// ==========================================================================
// Arithmetic layout
`define SAMPLE_W        10
`define COEF_W          10
`define PROD_W          20
`define ACC_W           23
`define SUM_W           16
`define GUARD_W         6
`define ROUND_FILL      6'h20
`define OUT_MSB         21
`define OUT_LSB         6
`define OVF_BIT         22
`define NUM_STAGES      3

// ==========================================================================
// Input buffer and timing
`define FIFO_DEPTH      8
`define FIFO_AW         3
`define FIFO_W          26
`define TARGET_CYCLE_NS 50
`define CLK_PERIOD_NS   10

`endif

//--- fir_cascade_cell.v
// Three-tap systolic FIR cascade cell with input FIFO and Avalon-MM control.
// ==========================================================================
// Overview of operation
// R1: Three multiply-add stages chained through registers.
// R2: All arithmetic is signed two's complement.
// R3: One sample, coefficient, result per clock; a coefficient write over the bus takes two clocks.
// R4: Optional zero-coefficient stage before each stage.
// R5: Sum input feeds first stage for cascading.
// R6: Three coefficients chosen by 2-bit select.
// R7: Inputs and sum output are registered.
// R8: 23-bit path, 16 MSBs at ports.
// R9: Six guard bits plus one overflow bit.
// R10: Overflow shown on a dedicated flag.
// R11: Round by adding half output LSB.
// R12: Select 00 holds; coefficient lands next clock.
// R13: Control low registers, high passes through.
// R14: Overflow tracks result; outputs follow enable.
// R15: Sum input padded 100000, registered when low.
// R16: Outputs meaningful after loading and pipeline fill.
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "fir_cell_regs.vh"

// ==========================================================================
// Synchronous FIFO
module stream_fifo #(
  parameter WIDTH = 26,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             ref_clk_i,
  input  wire             reset_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output reg              in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output reg              out_valid_o,
  input  wire             out_ready_i,
  output reg  [AW:0]      level_o
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_reg;
  reg  [AW-1:0]    rd_ptr_reg;
  wire             push;
  wire             pop;
  reg  [AW:0]      level_next;

  // Constants sized to the pointer and level widths, so that no sum is
  // widened or cut by accident.
  localparam [AW-1:0] PTR_STEP   = {{(AW-1){1'b0}}, 1'b1};
  localparam [AW:0]   LEVEL_STEP = {{AW{1'b0}}, 1'b1};
  localparam [AW:0]   LEVEL_FULL = DEPTH[AW:0];
  localparam [AW:0]   LEVEL_NONE = {(AW+1){1'b0}};

  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  // The head word is read straight from the array; a push never lands on
  // the head slot while out_valid_o is high, so the word holds until popped.
  assign out_data_o = mem[rd_ptr_reg];

  always @* begin
    level_next = level_o;
    if (push & ~pop) begin
      level_next = level_o + LEVEL_STEP;
    end else if (pop & ~push) begin
      level_next = level_o - LEVEL_STEP;
    end
  end

  always @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // Full and empty are kept as flops so that both handshake outputs are
  // registered; they are recomputed from the next level every cycle.
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      wr_ptr_reg  <= {AW{1'b0}};
      rd_ptr_reg  <= {AW{1'b0}};
      level_o     <= {(AW+1){1'b0}};
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PTR_STEP;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PTR_STEP;
      end
      level_o     <= level_next;
      in_ready_o  <= (level_next != LEVEL_FULL);
      out_valid_o <= (level_next != LEVEL_NONE);
    end
  end

endmodule // stream_fifo

// ==========================================================================
// Filter cell top level
module fir_cascade_cell (
  input  wire                  ref_clk_i,
  input  wire                  reset_i,
  // Avalon-MM slave.
  input  wire [3:0]            address_i,
  input  wire                  read_i,
  input  wire                  write_i,
  input  wire [3:0]            byteenable_i,
  input  wire [31:0]           writedata_i,
  output reg  [31:0]           readdata_o,
  output reg                   waitrequest_o,
  // Sample and partial sum stream in.
  input  wire [`SAMPLE_W-1:0]  sample_in_i,
  input  wire [`SUM_W-1:0]     sum_in_i,
  input  wire                  sample_valid_i,
  output wire                  sample_ready_o,
  // Result stream out.
  output reg  [`SUM_W-1:0]     sum_o,
  output reg                   sum_oe_o,
  output reg                   overflow_flag_o,
  output reg                   overflow_flag_oe_o,
  output reg                   result_valid_o,
  input  wire                  result_ready_i
);

  // ========================================================================
  // Bus slave
  reg  [2:0]               pipe_passthrough_ctrl_reg;
  reg                      out_enable_reg;
  reg  [1:0]               coef_write_select_reg;
  reg  [`COEF_W-1:0]       coef_in_reg;
  reg  [11:0]              coef_last_reg;
  reg  [`SUM_W-1:0]        result_reg;
  reg                      ovf_reg;
  wire [`FIFO_AW:0]        fifo_level;
  wire                     req;
  wire                     take;
  reg  [31:0]              read_next;

  assign req  = read_i | write_i;
  // The request completes on the edge where waitrequest is seen low.
  assign take = req & ~waitrequest_o;

  // Unmapped offsets read as zero and writes to them are dropped.
  always @* begin
    read_next = 32'h0000_0000;
    case (address_i)
      `OFS_CTRL: begin
        read_next[`CTRL_FT_MSB:`CTRL_FT_LSB] = pipe_passthrough_ctrl_reg;
        read_next[`CTRL_OE_BIT]              = out_enable_reg;
      end
      `OFS_COEF: begin
        read_next[`COEF_SEL_MSB:`COEF_VAL_LSB] = coef_last_reg;
      end
      `OFS_STATUS: begin
        read_next[`STAT_OVF_BIT]               = ovf_reg;
        read_next[`STAT_LVL_MSB:`STAT_LVL_LSB] = fifo_level;
      end
      `OFS_RESULT: begin
        read_next[`SUM_W-1:0] = result_reg;
      end
      default: begin
        read_next = 32'h0000_0000;
      end
    endcase
  end

  // One wait state per access: readdata is loaded while waitrequest is
  // high, so it is stable on the completing edge.
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      waitrequest_o             <= 1'b1;
      readdata_o                <= 32'h0000_0000;
      pipe_passthrough_ctrl_reg <= `CTRL_FT_RESET;
      out_enable_reg            <= `CTRL_OE_RESET;
      coef_write_select_reg     <= `SEL_NONE;
      coef_in_reg               <= {`COEF_W{1'b0}};
      coef_last_reg             <= 12'h000;
    end else begin
      waitrequest_o <= ~(req & waitrequest_o);
      if (req & waitrequest_o) begin
        readdata_o <= read_next;
      end
      // R12: selection lasts one clock
      coef_write_select_reg <= `SEL_NONE;
      if (take & write_i) begin
        if ((address_i == `OFS_CTRL) & byteenable_i[0]) begin
          // R13: passthrough control bits
          pipe_passthrough_ctrl_reg <= writedata_i[`CTRL_FT_MSB:`CTRL_FT_LSB];
          out_enable_reg            <= writedata_i[`CTRL_OE_BIT];
        end
        // Value and select straddle the two low lanes; a partial write
        // would land a half-formed word, so both lanes are required.
        if ((address_i == `OFS_COEF) & (byteenable_i[1:0] == 2'h3)) begin
          // R12: coefficient registered with code
          coef_write_select_reg <= writedata_i[`COEF_SEL_MSB:`COEF_SEL_LSB];
          coef_in_reg           <= writedata_i[`COEF_VAL_MSB:`COEF_VAL_LSB];
          coef_last_reg         <= writedata_i[`COEF_SEL_MSB:`COEF_VAL_LSB];
        end
      end
    end
  end

  // ========================================================================
  // Input buffer
  wire [`FIFO_W-1:0]       fifo_data;
  wire                     fifo_valid;
  wire                     advance;

  // The pipeline only steps when a sample is buffered and the result
  // register is free, so a stalled consumer fills the FIFO.
  assign advance = fifo_valid & (~result_valid_o | result_ready_i);

  // R7: input words registered in the buffer
  stream_fifo #(
    .WIDTH (`FIFO_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_in_fifo (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .in_data_i   ({sample_in_i, sum_in_i}),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (advance),
    .level_o     (fifo_level)
  );

  // ========================================================================
  // Systolic datapath
  reg  signed [`SAMPLE_W-1:0] data_reg;
  wire        [`ACC_W-1:0]    chain [0:`NUM_STAGES];
  wire        [`SUM_W-1:0]    fifo_sum;

  assign fifo_sum = fifo_data[`SUM_W-1:0];
  // R5: cascade input is the first addend
  // R15: padded with the half-LSB pattern
  // R11: rounding term added before truncation
  assign chain[0] = {fifo_sum[`SUM_W-1], fifo_sum, `ROUND_FILL};

  // R7: data input register
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      data_reg <= {`SAMPLE_W{1'b0}};
    end else if (advance) begin
      data_reg <= fifo_data[`FIFO_W-1:`SUM_W];
    end
  end

  // R1: three identical chained stages
  genvar g;
  generate
    for (g = 0; g < `NUM_STAGES; g = g + 1) begin : stage
      localparam integer STAGE_NUM = g + 1;
      localparam [1:0]   SEL_CODE  = STAGE_NUM[1:0];
      reg  signed [`COEF_W-1:0] coef_reg;
      reg         [`ACC_W-1:0]  hold_reg;
      reg         [`ACC_W-1:0]  acc_reg;
      wire signed [`PROD_W-1:0] prod;
      wire        [`ACC_W-1:0]  addend;

      // R6: one coefficient register per stage
      // R12: code 00 matches no stage
      always @(posedge ref_clk_i) begin
        if (reset_i) begin
          coef_reg <= {`COEF_W{1'b0}};
        end else if (coef_write_select_reg == SEL_CODE) begin
          coef_reg <= coef_in_reg;
        end
      end

      // R2: signed product
      assign prod = data_reg * coef_reg;
      // The hold register delays the incoming partial sum by one step; its
      // sum then meets the product of a later sample, acting as a zero tap.
      // R13: high bypasses the extra register
      // R4: low inserts a zero-coefficient stage
      assign addend = pipe_passthrough_ctrl_reg[g] ? chain[g] : hold_reg;

      always @(posedge ref_clk_i) begin
        if (reset_i) begin
          hold_reg <= {`ACC_W{1'b0}};
          acc_reg  <= {`ACC_W{1'b0}};
        end else if (advance) begin
          hold_reg <= chain[g];
          // R8: full-width accumulation
          acc_reg  <= {{(`ACC_W-`PROD_W){prod[`PROD_W-1]}}, prod} + addend;
        end
      end

      assign chain[g+1] = acc_reg;
    end
  endgenerate

  // ========================================================================
  // Output register and flag
  wire [`ACC_W-1:0] final_sum;
  wire [`SUM_W-1:0] result_word;
  wire              result_ovf;

  assign final_sum   = chain[`NUM_STAGES];
  // R9: guard bits dropped, top bit checked
  assign result_word = final_sum[`OUT_MSB:`OUT_LSB];
  // R10: overflow flag per result
  // Bit 22 disagreeing with bit 21 means the sum no longer fits 16 bits.
  assign result_ovf  = final_sum[`OVF_BIT] ^ final_sum[`OUT_MSB];

  // R16: validity depends on load and fill
  // Datapath registers start at zero, but results mean nothing until the
  // coefficients are loaded and the pipeline has stepped through.
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      result_reg         <= {`SUM_W{1'b0}};
      ovf_reg            <= 1'b0;
      result_valid_o     <= 1'b0;
      sum_o              <= {`SUM_W{1'b0}};
      overflow_flag_o    <= 1'b0;
      sum_oe_o           <= 1'b0;
      overflow_flag_oe_o <= 1'b0;
    end else begin
      // R14: port drive follows output enable
      sum_oe_o           <= out_enable_reg;
      overflow_flag_oe_o <= out_enable_reg;
      if (advance) begin
        // R8: sixteen result bits to ports
        result_reg      <= result_word;
        sum_o           <= result_word;
        // R14: cleared by next good result
        ovf_reg         <= result_ovf;
        overflow_flag_o <= result_ovf;
        // R3: one result per step
        result_valid_o  <= 1'b1;
      end else if (result_ready_i) begin
        result_valid_o  <= 1'b0;
      end
    end
  end

endmodule // fir_cascade_cell

`default_nettype wire

//--- fir_cell_checker.sv
// Port-level assertions for the FIR cascade cell.
`timescale 1ns/1ns
`default_nettype none
module fir_cell_checker (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic [3:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [3:0]  byteenable_i,
  input wire logic [31:0] writedata_i,
  input wire logic        waitrequest_o,
  input wire logic        sample_ready_o,
  input wire logic [15:0] sum_o,
  input wire logic        sum_oe_o,
  input wire logic        overflow_flag_o,
  input wire logic        overflow_flag_oe_o,
  input wire logic        result_valid_o,
  input wire logic        result_ready_i
);
  // ==========================================================================
  // Checks
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  property p_wait_one; (read_i || write_i) && waitrequest_o |=> !waitrequest_o; endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus request not answered after one wait state");
  property p_wait_short; !waitrequest_o |=> waitrequest_o; endproperty
  a_wait_short: assert property (p_wait_short)
    else $error("waitrequest low for more than one cycle");
  property p_hold; result_valid_o && !result_ready_i
    |=> result_valid_o && $stable(sum_o) && $stable(overflow_flag_o); endproperty
  a_hold: assert property (p_hold)
    else $error("result changed while stalled");
  property p_oe_pair; sum_oe_o == overflow_flag_oe_o; endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("flag and sum enables differ");
  property p_oe_follow; write_i && !waitrequest_o && address_i == 4'h0 && byteenable_i[0]
    |-> ##2 sum_oe_o == $past(writedata_i[3], 2); endproperty
  a_oe_follow: assert property (p_oe_follow)
    else $error("output enable did not follow control write");
  property p_reset_out; disable iff (1'b0) reset_i
    |=> waitrequest_o && !sample_ready_o && !result_valid_o && !sum_oe_o; endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not idle under reset");
  property p_ready_rel; $fell(reset_i) |=> sample_ready_o; endproperty
  a_ready_rel: assert property (p_ready_rel)
    else $error("input not ready after reset release");
  property p_sum_moves; !$stable(sum_o) |-> result_valid_o; endproperty
  a_sum_moves: assert property (p_sum_moves)
    else $error("sum changed without a new result");
endmodule // fir_cell_checker
`default_nettype wire

//--- stream_partner.sv
// Upstream word source and downstream result sink facing the filter cell.
`timescale 1ns/1ns
`default_nettype none
module stream_partner (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        offer_i,
  input  wire logic        sink_i,
  input  wire logic [25:0] next_word_i,
  input  wire logic        sample_ready_i,
  output var  logic [9:0]  sample_o,
  output var  logic [15:0] sum_o,
  output var  logic        valid_o,
  output wire logic        result_ready_o
);
  assign result_ready_o = sink_i;
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      {sample_o, sum_o} <= 26'h0;
      valid_o <= 1'b0;
    end else if (!valid_o || sample_ready_i) begin
      // Idle lines keep changing so a stale word is never mistaken for a fresh one.
      {sample_o, sum_o} <= next_word_i;
      valid_o <= offer_i;
    end
  end
endmodule // stream_partner
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the FIR cascade cell.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic ref_clk_i, reset_i, read_i, write_i, offer, sink_en, snk, svalid, sready, wreq;
  logic rvalid, rready, sum_oe, ov, ov_oe, ov_m;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, rd, v, lfsr = 32'h0712d14b;
  logic [25:0] next_word;
  logic [9:0] sample;
  logic [15:0] sum_in, sum_out, res;
  logic [25:0] words[$];
  logic signed [22:0] acc[3], hold[3];
  logic signed [9:0] coef[3], dreg;
  logic [2:0] ft;
  logic [2:0] ft_tbl[4] = '{3'h7, 3'h0, 3'h5, 3'h2};
  integer err_count, comparisons, i, n, k;

  fir_cascade_cell fir_cascade_cell_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .address_i(address), .read_i(read_i), .write_i(write_i), .byteenable_i(byteenable),
    .writedata_i(writedata), .readdata_o(readdata), .waitrequest_o(wreq),
    .sample_in_i(sample), .sum_in_i(sum_in), .sample_valid_i(svalid),
    .sample_ready_o(sready), .sum_o(sum_out), .sum_oe_o(sum_oe), .overflow_flag_o(ov),
    .overflow_flag_oe_o(ov_oe), .result_valid_o(rvalid), .result_ready_i(rready));
  stream_partner stream_partner_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .offer_i(offer), .sink_i(snk), .next_word_i(next_word), .sample_ready_i(sready),
    .sample_o(sample), .sum_o(sum_in), .valid_o(svalid), .result_ready_o(rready));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (e !== s) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    integer t;
    @(posedge ref_clk_i);
    address <= a; writedata <= d; byteenable <= 4'hf; read_i <= !w; write_i <= w;
    t = 0;
    do begin @(posedge ref_clk_i); t++; end while (wreq !== 1'b0 && t < 20);
    rd = readdata;
    read_i <= 1'b0; write_i <= 1'b0;
    if (wreq !== 1'b0) begin err_count++; test_done; end
  endtask
  // Reference step: product uses the previous sample, sums ride the chain.
  task automatic step(input logic [25:0] w);
    logic signed [22:0] c[3];
    logic signed [22:0] p;
    res = acc[2][21:6]; ov_m = acc[2][22] ^ acc[2][21];
    c[0] = {w[15], w[15:0], 6'h20}; c[1] = acc[0]; c[2] = acc[1];
    for (int g = 0; g < 3; g++) begin
      p = dreg * coef[g];
      acc[g] = p + (ft[g] ? c[g] : hold[g]);
      hold[g] = c[g];
    end
    dreg = w[25:16];
  endtask

  // ==========================================================================
  // Stimulus and monitor
  initial begin ref_clk_i = 0; forever #5 ref_clk_i = ~ref_clk_i; end
  always @(posedge ref_clk_i) begin
    lfsr <= nx(lfsr); next_word <= lfsr[25:0]; snk <= sink_en & (lfsr[4] | lfsr[9]);
    if (!reset_i && svalid && sready) words.push_back({sample, sum_in});
    if (!reset_i && rvalid && rready) begin
      if (words.size() == 0) chk("queue", 1, 0);
      else begin
        step(words.pop_front());
        chk("sum", res, sum_out);
        chk("ovf", ov_m, ov);
      end
    end
  end
  initial begin repeat (20000) @(posedge ref_clk_i); err_count++; test_done; end
  initial begin
    reset_i = 1; read_i = 0; write_i = 0; address = 0; byteenable = 0; writedata = 0;
    offer = 0; sink_en = 0; err_count = 0; comparisons = 0;
    ft = 3'h7; dreg = 0;
    for (i = 0; i < 3; i++) begin acc[i] = 0; hold[i] = 0; coef[i] = 0; end
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 0;
    bus(0, 4'h0, 0); chk("ctrl", 32'h7, rd & 32'hf);
    bus(0, 4'h6, 0); chk("unmapped", 0, rd);
    for (n = 0; n < 4; n++) begin
      for (i = 1; i < 4; i++) begin
        v = lfsr;
        bus(1, 4'h4, {20'h0, i[1:0], v[9:0]}); coef[i-1] = v[9:0];
      end
      v = ~lfsr;
      bus(1, 4'h4, {20'h0, 2'b00, v[9:0]});
      bus(0, 4'h4, 0); chk("coef", {20'h0, 2'b00, v[9:0]}, rd & 32'hfff);
      bus(1, 4'h0, {28'h0, 1'b1, ft_tbl[n]}); ft = ft_tbl[n];
      offer <= 1; sink_en <= (n != 1);
      if (n == 1) begin
        for (k = 0; k < 60 && sready !== 1'b0; k++) @(posedge ref_clk_i);
        if (sready !== 1'b0) begin err_count++; test_done; end
        bus(0, 4'h8, 0); chk("level", 8, (rd >> 1) & 32'hf);
        sink_en <= 1;
      end
      repeat (40) @(posedge ref_clk_i);
      offer <= 0;
      for (k = 0; k < 300 && (words.size() != 0 || svalid !== 1'b0); k++)
        @(posedge ref_clk_i);
      if (words.size() != 0 || svalid !== 1'b0) begin err_count++; test_done; end
      repeat (3) @(posedge ref_clk_i);
      chk("oe", 1, sum_oe);
      chk("flag_oe", 1, ov_oe);
    end
    bus(0, 4'h8, 0); chk("stat_ovf", ov_m, rd[0]);
    bus(0, 4'hc, 0); chk("result", res, rd);
    bus(1, 4'h0, {28'h0, 1'b0, 3'h7});
    repeat (2) @(posedge ref_clk_i);
    chk("oe_off", 0, sum_oe);
    chk("flag_oe_off", 0, ov_oe);
    test_done;
  end
endmodule // testbench

bind fir_cascade_cell fir_cell_checker fir_cell_checker_inst (.ref_clk_i, .reset_i,
  .address_i, .read_i, .write_i, .byteenable_i, .writedata_i, .waitrequest_o,
  .sample_ready_o, .sum_o, .sum_oe_o, .overflow_flag_o, .overflow_flag_oe_o,
  .result_valid_o, .result_ready_i);
`default_nettype wire
